// [hw/radio_defines.svh]
// Register offsets, field positions, reset values and timing constants
`ifndef RADIO_DEFINES_SVH
`define RADIO_DEFINES_SVH

// Bank-0 register offsets
`define ADDR_CONFIG     3'h0
`define ADDR_AUTO_ACK   3'h1
`define ADDR_RX_PIPES   3'h2
`define ADDR_AW         3'h3
`define ADDR_RETR       3'h4
`define ADDR_CHANNEL    3'h5
`define ADDR_RADIO_SETUP   3'h6
`define ADDR_STATUS     3'h7

// Configuration register fields
`define CFG_MASK_RX     6
`define CFG_MASK_TX     5
`define CFG_MASK_RT     4
`define CFG_CRC_EN      3
`define CFG_CRC_LEN     2
`define CFG_POWER_ON_BIT      1
`define CFG_ROLE        0

// Radio setup register fields
`define RF_RATE_LOW     5
`define RF_LOCK         4
`define RF_RATE_HIGH    3
`define RF_GAIN         0

// Status register fields
`define ST_BANK         7

// Reset values
`define RST_CONFIG      8'h08
`define RST_AUTO_ACK    8'h3f
`define RST_RX_PIPES    8'h03
`define RST_AW          8'h03
`define RST_RETR        8'h03
`define RST_CHANNEL     8'h02
`define RST_RADIO_SETUP    8'h0f

// Writable bits, reserved bits read as zero
`define WM_CONFIG       8'h7f
`define WM_AUTO_ACK     8'h3f
`define WM_RX_PIPES     8'h3f
`define WM_AW           8'h03
`define WM_RETR         8'hff
`define WM_CHANNEL      8'h7f
`define WM_RADIO_SETUP     8'h3f

// Serial commands
`define CMD_READ_TOP    3'h0
`define CMD_WRITE_TOP   3'h1
`define CMD_ACTIVATE    8'h50
`define KEY_BANK        8'h53
`define KEY_FEATURE     8'h73

// Timing
`define CLOCK_FREQ_KHZ  20000
`define RETRY_STEP_US   250
`define RETRY_STEP_CYC  (`RETRY_STEP_US * `CLOCK_FREQ_KHZ / 1000)

`endif

// [hw/radio_pkg.sv]
// Types shared by the radio configuration block
package radio_pkg;
  typedef enum logic [1:0] {rate_1m, rate_2m, rate_250k} data_rate_t;
  typedef enum logic {retry_idle, retry_waiting} retry_state_t;
endpackage : radio_pkg

// [hw/spi_byte_shifter.sv]
// Serial-clock side: byte assembly, status and read data shift-out
`timescale 1ns/1ns
`include "radio_defines.svh"
module spi_byte_shifter (
  input  wire logic        sck,
  input  wire logic        csn_n,
  input  wire logic        rst,
  input  wire logic        mosi,
  input  wire logic [63:0] read_shadow,
  output logic [7:0]       byte_data,
  output logic [1:0]       byte_index,
  output logic             byte_toggle,
  output logic             miso,
  output logic             miso_oe
);
  logic [2:0] bit_cnt;
  logic [2:0] lead_cnt;
  logic [1:0] byte_cnt;
  logic [6:0] rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] frame_cmd;
  logic       rd_hit;

  // Frame counters, cleared whenever the chip select is idle
  always_ff @(posedge sck or posedge csn_n) begin
    if (csn_n) begin
      bit_cnt   <= 3'h0;
      byte_cnt  <= 2'h0;
      rx_shift  <= 7'h00;
      frame_cmd <= 8'hff;
    end else begin
      bit_cnt  <= bit_cnt + 3'h1;
      rx_shift <= {rx_shift[5:0], mosi};
      if (bit_cnt == 3'h7 && byte_cnt != 2'h3) begin
        byte_cnt <= byte_cnt + 2'h1;
      end
      if (bit_cnt == 3'h7 && byte_cnt == 2'h0) begin
        frame_cmd <= {rx_shift, mosi};
      end
    end
  end

  // Completed byte handed to the system clock with a toggle
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      byte_data   <= 8'h00;
      byte_index  <= 2'h0;
      byte_toggle <= 1'b0;
    end else if (!csn_n && bit_cnt == 3'h7) begin
      byte_data   <= {rx_shift, mosi};
      byte_index  <= (byte_cnt == 2'h3) ? 2'h2 : byte_cnt;
      byte_toggle <= ~byte_toggle;
    end
  end

  assign rd_hit = frame_cmd[7:5] == `CMD_READ_TOP && frame_cmd[4:3] == 2'h0;

  // Read data loads after the command byte and shifts on falling edges
  // Status bit pointer also steps on falling edges, so the host never sees it move at its sample
  always_ff @(negedge sck or posedge csn_n) begin
    if (csn_n) begin
      tx_shift <= 8'h00;
      lead_cnt <= 3'h0;
    end else begin
      lead_cnt <= lead_cnt + 3'h1;
      if (bit_cnt == 3'h0 && byte_cnt == 2'h1) begin
        tx_shift <= rd_hit ? read_shadow[{frame_cmd[2:0], 3'h0} +: 8] : 8'h00;
      end else begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // Status leaves during the command byte, read data afterwards
  assign miso    = (byte_cnt == 2'h0) ? read_shadow[6'd63 - {3'h0, lead_cnt}] : tx_shift[7];
  assign miso_oe = ~csn_n;

  byte_done_a: assert property (@(posedge sck) disable iff (csn_n || rst)
    bit_cnt == 3'h7 |=> byte_toggle != $past(byte_toggle))
    else $error("byte completion did not toggle");
endmodule : spi_byte_shifter

// [hw/radio_config_register_bank.sv]
// Bank-0 configuration registers of the radio, reached over SPI
`timescale 1ns/1ns
`include "radio_defines.svh"
module radio_config_register_bank
  import radio_pkg::*;
#(
  parameter int RETRY_STEP_CYCLES = `RETRY_STEP_CYC
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       sck,
  input  wire logic       csn_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe,
  input  wire logic       rx_ready_event,
  input  wire logic       tx_done_event,
  input  wire logic       tx_ack_fail,
  input  wire logic [2:0] rx_pipe_number,
  input  wire logic       tx_fifo_full,
  output logic            irq_n,
  output logic            power_on_bit,
  output logic            role_select,
  output logic            crc_enable,
  output logic            checksum_length_select,
  output logic [5:0]      ack_pipe_enable,
  output logic [5:0]      rx_pipe_enable,
  output logic [2:0]      address_width_bytes,
  output logic [4:0]      address_byte_enable,
  output logic [6:0]      radio_channel,
  output data_rate_t      data_rate,
  output logic            force_lock,
  output logic [1:0]      transmit_power_level,
  output logic            receiver_gain_select,
  output logic            retransmit_start,
  output logic [3:0]      retry_used,
  output logic            bank_indicator,
  output logic            features_active
);
  localparam logic [55:0] RESET_IMAGE = {`RST_RADIO_SETUP, `RST_CHANNEL, `RST_RETR,
    `RST_AW, `RST_RX_PIPES, `RST_AUTO_ACK, `RST_CONFIG};
  localparam logic [55:0] WRITE_MASK = {`WM_RADIO_SETUP, `WM_CHANNEL, `WM_RETR,
    `WM_AW, `WM_RX_PIPES, `WM_AUTO_ACK, `WM_CONFIG};

  logic [7:0]   cfg_regs [0:6];
  logic [7:0]   byte_data;
  logic [1:0]   byte_index;
  logic         byte_toggle;
  logic         tog_s1;
  logic         tog_s2;
  logic         tog_s3;
  logic         cs_s1;
  logic         cs_s2;
  logic [7:0]   cmd;
  logic [63:0]  read_shadow;
  logic [2:0]   flags;
  retry_state_t retry_state;
  logic [16:0]  wait_count;

  // Serial side runs on the host's clock
  spi_byte_shifter u_shifter (
    .sck         (sck),
    .csn_n       (csn_n),
    .rst         (rst),
    .mosi        (mosi),
    .read_shadow (read_shadow),
    .byte_data   (byte_data),
    .byte_index  (byte_index),
    .byte_toggle (byte_toggle),
    .miso        (miso),
    .miso_oe     (miso_oe)
  );

  // Toggle and chip select synchronisers
  always_ff @(posedge clock) begin
    if (rst) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
    end else begin
      tog_s1 <= byte_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      cs_s1  <= csn_n;
      cs_s2  <= cs_s1;
    end
  end

  // Command decode on each received byte
  wire       byte_strobe  = tog_s2 ^ tog_s3;
  wire       first_data   = byte_strobe && byte_index == 2'h1;
  wire       write_cmd    = cmd[7:5] == `CMD_WRITE_TOP && cmd[4:3] == 2'h0;
  wire       write_hit    = first_data && write_cmd && !bank_indicator;
  wire       activate_hit = first_data && cmd == `CMD_ACTIVATE;
  wire       bank_flip    = activate_hit && byte_data == `KEY_BANK;
  wire       feature_flip = activate_hit && byte_data == `KEY_FEATURE;
  wire       status_write = write_hit && cmd[2:0] == `ADDR_STATUS;

  // Command byte of the current frame
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd <= 8'hff;
    end else if (byte_strobe && byte_index == 2'h0) begin
      cmd <= byte_data;
    end
  end

  // Storage for the seven read-write registers
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_reg
      always_ff @(posedge clock) begin
        if (rst) begin
          cfg_regs[gi] <= RESET_IMAGE[gi*8 +: 8];
        end else if (write_hit && cmd[2:0] == 3'(gi)) begin
          cfg_regs[gi] <= byte_data & WRITE_MASK[gi*8 +: 8];
        end
      end
    end
  endgenerate

  // Field views
  wire       mask_receive_ready   = cfg_regs[0][`CFG_MASK_RX];
  wire       mask_transmit_done   = cfg_regs[0][`CFG_MASK_TX];
  wire       mask_retry_exhausted = cfg_regs[0][`CFG_MASK_RT];
  wire       crc_forced           = |cfg_regs[1][5:0];
  wire       crc_effective        = cfg_regs[0][`CFG_CRC_EN] | crc_forced;
  wire [7:0] config_view          = {cfg_regs[0][7:4], crc_effective, cfg_regs[0][2:0]};
  wire [1:0] address_width_code   = cfg_regs[3][1:0];
  wire [3:0] retry_delay          = cfg_regs[4][7:4];
  wire [3:0] retry_limit          = cfg_regs[4][3:0];
  wire       rate_low_bit         = cfg_regs[6][`RF_RATE_LOW];
  wire       rate_high_bit        = cfg_regs[6][`RF_RATE_HIGH];
  wire [2:0] event_masks = {mask_receive_ready, mask_transmit_done, mask_retry_exhausted};

  // Address width decode, illegal code gives no bytes
  wire [2:0] aw_bytes = (address_width_code == 2'h0) ? 3'h0
                      : 3'({1'b0, address_width_code} + 3'h2);
  wire [4:0] aw_enable = (aw_bytes == 3'h5) ? 5'h1f
                       : (aw_bytes == 3'h4) ? 5'h0f
                       : (aw_bytes == 3'h3) ? 5'h07 : 5'h00;

  // Air rate decode from the low and high bits
  wire [1:0]  rate_pair = {rate_low_bit, rate_high_bit};
  wire data_rate_t rate_decoded = (rate_pair == 2'b00) ? rate_1m
                                : (rate_pair == 2'b10) ? rate_250k : rate_2m;

  // Retransmission control
  wire        can_retry   = retry_used < retry_limit;
  wire        retry_idle_now = retry_state == retry_idle;
  wire        retry_begin = tx_ack_fail && retry_idle_now && can_retry;
  wire        retry_give_up = tx_ack_fail && retry_idle_now && !can_retry;
  wire        wait_done   = retry_state == retry_waiting && wait_count == 17'h1;
  wire [16:0] wait_load   = 17'((int'(retry_delay) + 1) * RETRY_STEP_CYCLES);

  // Wait between a failed transmission and its retry
  always_ff @(posedge clock) begin
    if (rst) begin
      retry_state      <= retry_idle;
      wait_count       <= 17'h0;
      retry_used       <= 4'h0;
      retransmit_start <= 1'b0;
    end else begin
      retransmit_start <= wait_done;
      case (retry_state)
        retry_idle: begin
          if (retry_begin) begin
            retry_state <= retry_waiting;
            wait_count  <= wait_load;
            retry_used  <= retry_used + 4'h1;
          end else if (retry_give_up || tx_done_event) begin
            retry_used <= 4'h0;
          end
        end
        retry_waiting: begin
          wait_count <= wait_count - 17'h1;
          if (wait_done) begin
            retry_state <= retry_idle;
          end
        end
        default: retry_state <= retry_idle;
      endcase
    end
  end

  // Event flags: set wins over a write-one clear
  wire [2:0] flag_set   = {rx_ready_event, tx_done_event, retry_give_up};
  wire [2:0] flag_clear = status_write ? byte_data[6:4] : 3'h0;
  wire [2:0] next_flags = (flags & ~flag_clear) | flag_set;
  wire [7:0] status_view = {bank_indicator, flags, rx_pipe_number, tx_fifo_full};

  // Flags, bank and feature toggles
  always_ff @(posedge clock) begin
    if (rst) begin
      flags           <= 3'h0;
      bank_indicator  <= 1'b0;
      features_active <= 1'b0;
    end else begin
      flags <= next_flags;
      if (bank_flip) begin
        bank_indicator <= ~bank_indicator;
      end
      if (feature_flip) begin
        features_active <= ~features_active;
      end
    end
  end

  // Register image seen by the serial side; in bank 1 every register but status reads as zero
  wire [55:0] bank0_image = {cfg_regs[6], cfg_regs[5], cfg_regs[4], cfg_regs[3],
                             cfg_regs[2], cfg_regs[1], config_view};
  wire [63:0] reg_image = {status_view, bank_indicator ? 56'h0 : bank0_image};

  // Snapshot refreshed only while the host is deselected
  always_ff @(posedge clock) begin
    if (rst) begin
      read_shadow <= 64'h0;
    end else if (cs_s2) begin
      read_shadow <= reg_image;
    end
  end

  // Registered control outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_n                  <= 1'b1;
      power_on_bit           <= 1'b0;
      role_select            <= 1'b0;
      crc_enable             <= 1'b1;
      checksum_length_select <= 1'b0;
      ack_pipe_enable        <= 6'h3f;
      rx_pipe_enable         <= 6'h03;
    end else begin
      irq_n                  <= ~|(flags & ~event_masks);
      power_on_bit           <= cfg_regs[0][`CFG_POWER_ON_BIT];
      role_select            <= cfg_regs[0][`CFG_ROLE];
      crc_enable             <= crc_effective;
      checksum_length_select <= cfg_regs[0][`CFG_CRC_LEN];
      ack_pipe_enable        <= cfg_regs[1][5:0];
      rx_pipe_enable         <= cfg_regs[2][5:0];
    end
  end

  // Registered radio outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      address_width_bytes  <= 3'h5;
      address_byte_enable  <= 5'h1f;
      radio_channel        <= 7'h02;
      data_rate            <= rate_2m;
      force_lock           <= 1'b0;
      transmit_power_level <= 2'h3;
      receiver_gain_select <= 1'b1;
    end else begin
      address_width_bytes  <= aw_bytes;
      address_byte_enable  <= aw_enable;
      radio_channel        <= cfg_regs[5][6:0];
      data_rate            <= rate_decoded;
      force_lock           <= cfg_regs[6][`RF_LOCK];
      transmit_power_level <= cfg_regs[6][2:1];
      receiver_gain_select <= cfg_regs[6][`RF_GAIN];
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_rx_unmasked;
    rx_ready_event ##1 !mask_receive_ready;
  endsequence

  sequence s_wait_start;
    retry_begin ##1 (retry_state == retry_waiting);
  endsequence

  crc_forced_a: assert property (crc_forced |=> crc_enable)
    else $error("checksum enable not forced");

  irq_unmasked_a: assert property (s_rx_unmasked |=> !irq_n)
    else $error("unmasked receive event missed the interrupt");

  irq_masked_a: assert property (flags == 3'h0 ##1 flags == 3'h0 |=> irq_n)
    else $error("interrupt low with no event");

  event_wins_a: assert property (rx_ready_event |=> flags[2])
    else $error("event lost against a clear");

  bank_flip_a: assert property (bank_flip |=> bank_indicator != $past(bank_indicator))
    else $error("bank did not toggle");

  retry_wait_a: assert property (s_wait_start |-> wait_count == $past(wait_load))
    else $error("retry wait loaded wrong");

  retry_pulse_a: assert property (wait_done |=> retransmit_start ##1 !retransmit_start)
    else $error("retransmit start not a single pulse");

  retry_limit_a: assert property (tx_ack_fail && retry_idle_now && retry_used >= retry_limit
    |=> flags[0] && retry_state == retry_idle)
    else $error("retry limit not honoured");

  aw_width_a: assert property (address_width_code == 2'h1 ##1 address_width_code == 2'h1
    |=> address_width_bytes == 3'h3 && address_byte_enable == 5'h07)
    else $error("address width decode wrong");

  rate_slow_a: assert property (rate_pair == 2'b10 |=> data_rate == rate_250k)
    else $error("rate decode wrong");
endmodule : radio_config_register_bank

// [tb/spi_host_model.sv]
// Host microcontroller model: SPI master, mode 0, clock only within frames
`timescale 1ns/1ns
module spi_host_model (
  output logic      sck,
  output logic      csn_n,
  output logic      mosi,
  input  wire logic miso
);
  // Idle bus: deselected, serial clock low
  initial begin
    sck = 1'b0;
    csn_n = 1'b1;
    mosi = 1'b0;
  end

  // One frame: command byte then one data byte, status and reply captured
  task automatic frame(input logic [7:0] cmd, input logic [7:0] dat,
                       output logic [7:0] st, output logic [7:0] rd);
    logic [15:0] tx;
    logic [15:0] rx;
    tx = {cmd, dat};
    csn_n = 1'b0;
    #250;
    // Data changes after the falling edge, sampled on the rising edge
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      #16 sck = 1'b1;
      rx[i] = miso;
      #16 sck = 1'b0;
      if (i == 8) begin
        #400;
      end
    end
    #20 csn_n = 1'b1;
    mosi = ~mosi; // Released line shows no stale value
    st = rx[15:8];
    rd = rx[7:0];
    #400;
  endtask : frame
endmodule : spi_host_model

// [tb/tb_radio_config_register_bank.sv]
// Self-checking bench for the radio configuration register bank
`timescale 1ns/1ns
module tb_radio_config_register_bank;
  import radio_pkg::*;
  localparam int STEP = 4;
  localparam logic [7:0] WM [7] = '{8'h7f, 8'h3f, 8'h3f, 8'h03, 8'hff, 8'h7f, 8'h3f};
  localparam logic [7:0] RETR [3] = '{8'h12, 8'h01, 8'hf1};
  logic       clock, rst, sck, csn_n, mosi, miso, miso_oe, irq_n;
  logic       rx_ready_event, tx_done_event, tx_ack_fail, tx_fifo_full;
  logic [2:0] rx_pipe_number, address_width_bytes;
  logic       power_on_bit, role_select, crc_enable, checksum_length_select;
  logic [5:0] ack_pipe_enable, rx_pipe_enable;
  logic [4:0] address_byte_enable;
  logic [6:0] radio_channel;
  data_rate_t data_rate;
  logic       force_lock, receiver_gain_select, retransmit_start;
  logic       bank_indicator, features_active;
  logic [1:0] transmit_power_level;
  logic [3:0] retry_used, ru;
  wire        miso_line;
  logic [7:0] rg [8];
  logic [7:0] rdv;
  logic       rxf, txf, rtf, bnk, fea;
  int         miscompares, samples_checked, seed;

  radio_config_register_bank #(.RETRY_STEP_CYCLES(STEP)) i_dut (
    .clock, .rst, .sck, .csn_n, .mosi, .miso, .miso_oe, .rx_ready_event,
    .tx_done_event, .tx_ack_fail, .rx_pipe_number, .tx_fifo_full, .irq_n,
    .power_on_bit, .role_select, .crc_enable, .checksum_length_select,
    .ack_pipe_enable, .rx_pipe_enable, .address_width_bytes, .address_byte_enable,
    .radio_channel, .data_rate, .force_lock, .transmit_power_level,
    .receiver_gain_select, .retransmit_start, .retry_used, .bank_indicator,
    .features_active
  );
  spi_host_model host (.sck, .csn_n, .mosi, .miso(miso_line));

  // Serial output is only driven while selected
  assign miso_line = miso_oe ? miso : 1'bz;

  // System clock, 50 ns period
  always #25 clock = ~clock;

  // Byte comparison
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte

  // All decoded outputs against the model
  task automatic chk_ports;
    logic [1:0]  aw;
    logic [1:0]  rt;
    logic        irq;
    logic [43:0] e;
    logic [43:0] g;
    #1; // Step past the clock edge that updates outputs
    aw = rg[3][1:0];
    rt = {rg[6][5], rg[6][3]};
    irq = ~((rxf & ~rg[0][6]) | (txf & ~rg[0][5]) | (rtf & ~rg[0][4]));
    e = {rg[0][1], rg[0][0], rg[0][3] | (|rg[1][5:0]), rg[0][2], rg[1][5:0], rg[2][5:0],
         (aw == 2'h0) ? 3'h0 : 3'(aw) + 3'h2, (aw == 2'h0) ? 5'h00 : 5'h1f >> (2'h3 - aw),
         rg[5][6:0], (rt == 2'h0) ? rate_1m : (rt == 2'h2) ? rate_250k : rate_2m,
         rg[6][4], rg[6][2:1], rg[6][0], bnk, fea, ru, irq};
    g = {power_on_bit, role_select, crc_enable, checksum_length_select, ack_pipe_enable,
         rx_pipe_enable, address_width_bytes, address_byte_enable, radio_channel, data_rate,
         force_lock, transmit_power_level, receiver_gain_select, bank_indicator,
         features_active, retry_used, irq_n};
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t ports got %h exp %h", $time, g, e);
    end
  endtask : chk_ports

  // One frame with fresh status inputs, status checked during the command
  task automatic xf(input logic [7:0] cmd, input logic [7:0] dat);
    logic [7:0] st;
    @(posedge clock);
    #5 {rx_pipe_number, tx_fifo_full} = 4'($random(seed));
    repeat (3) @(posedge clock);
    #5 host.frame(cmd, dat, st, rdv);
    chk_byte(st, {bnk, rxf, txf, rtf, rx_pipe_number, tx_fifo_full});
    chk_byte({7'h0, miso_oe}, 8'h00);
  endtask : xf

  // Register write, then the model follows
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xf({3'h1, a}, d);
    if (a == 5'h7 && !bnk) begin
      {rxf, txf, rtf} = {rxf, txf, rtf} & ~d[6:4];
    end else if (a < 5'h7 && !bnk) begin
      rg[a[2:0]] = d;
    end
    repeat (2) @(posedge clock);
    chk_ports;
  endtask : wr

  // Register read against the model
  task automatic rdr(input logic [2:0] a);
    logic [7:0] e;
    xf({5'h0, a}, 8'h00);
    e = (a == 3'h7) ? {bnk, rxf, txf, rtf, rx_pipe_number, tx_fifo_full} : bnk ? 8'h00 : rg[a];
    if (a == 3'h0 && !bnk) begin
      e[3] = e[3] | (|rg[1][5:0]);
    end
    chk_byte(rdv, e);
  endtask : rdr

  // Unlock command with one data byte
  task automatic act(input logic [7:0] d);
    xf(8'h50, d);
    bnk = bnk ^ (d == 8'h53);
    fea = fea ^ (d == 8'h73);
    repeat (2) @(posedge clock);
    chk_ports;
  endtask : act

  // One-cycle pulse on one event input
  task automatic ev(input int k);
    @(posedge clock);
    #5 {rx_ready_event, tx_done_event, tx_ack_fail} = 3'b100 >> k;
    @(posedge clock);
    #5 {rx_ready_event, tx_done_event, tx_ack_fail} = 3'b000;
  endtask : ev

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog against a hang
  initial begin
    #3000000;
    miscompares++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  // Main sequence
  initial begin
    int         n;
    int         w;
    logic [7:0] d;
    logic [7:0] c;
    clock = 1'b0;
    rst = 1'b1;
    {rx_ready_event, tx_done_event, tx_ack_fail, rx_pipe_number, tx_fifo_full} = 7'h00;
    seed = 34;
    miscompares = 0;
    samples_checked = 0;
    rg = '{8'h08, 8'h3f, 8'h03, 8'h03, 8'h03, 8'h02, 8'h0f, 8'h00};
    {rxf, txf, rtf, bnk, fea, ru} = 9'h000;
    repeat (4) @(posedge clock);
    #5 rst = 1'b0;
    repeat (4) @(posedge clock);
    chk_ports;
    for (int a = 0; a < 8; a++) begin
      rdr(3'(a));
    end
    // Random settings, every width code and rate pair, reserved bits zero
    for (int i = 0; i < 8; i++) begin
      for (int a = 0; a < 7; a++) begin
        d = 8'($random(seed)) & WM[a];
        if (a == 1 && i[0]) begin
          d = 8'h00;
        end
        if (a == 3) begin
          d = {6'h0, 2'(i)};
        end
        if (a == 6) begin
          d = (d & 8'hd7) | {2'h0, i[2], 1'b0, i[1], 3'h0};
        end
        wr(5'(a), d);
      end
      wr(5'h08, 8'h5a);
      wr(5'h1f, 8'hff);
      for (int a = 0; a < 7; a++) begin
        rdr(3'(a));
      end
    end
    // Event masking; a failed ack with a zero retry limit exhausts at once
    wr(5'h4, 8'h00);
    for (int m = 0; m < 8; m++) begin
      wr(5'h0, {1'b0, 3'(m), rg[0][3:0]});
      for (int k = 0; k < 3; k++) begin
        ev(k);
        rxf = rxf | (k == 0);
        txf = txf | (k == 1);
        rtf = rtf | (k == 2);
        repeat (3) @(posedge clock);
        chk_ports;
      end
      rdr(3'h7);
      wr(5'h7, 8'h70);
    end
    // Retry delay and limit
    for (int j = 0; j < 3; j++) begin
      c = RETR[j];
      wr(5'h4, c);
      w = (int'(c[7:4]) + 1) * STEP;
      for (int k = 0; k <= int'(c[3:0]); k++) begin
        ev(2);
        if (k < int'(c[3:0])) begin
          n = 0;
          while (retransmit_start !== 1'b1 && n < 300) begin
            @(posedge clock);
            #1 n++;
          end
          chk_byte({7'h0, (n >= w) && (n <= w + 2)}, 8'h01);
          ru = 4'(k + 1);
        end else begin
          rtf = 1'b1;
          ru = 4'h0;
        end
        repeat (3) @(posedge clock);
        chk_ports;
      end
      rdr(3'h7);
      wr(5'h7, 8'h10);
    end
    // Bank toggling, writes ignored in the other bank, other unlock data
    act(8'h53);
    rdr(3'h7);
    wr(5'h5, 8'h11);
    rdr(3'h5);
    act(8'h42);
    act(8'h73);
    act(8'h53);
    rdr(3'h5);
    rdr(3'h7);
    tally_and_finish();
  end
endmodule : tb_radio_config_register_bank
